// >>> stm_defines.svh
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// Channel count: 0..4 plus X
`define STM_NCH        6
`define STM_CHX        5
`define STM_NPULSE     4
`define STM_PULSE_BASE 2
`define STM_NEXT       8

// Byte addresses, channel block i at i*16
`define STM_OFS_DATA     4'h0
`define STM_OFS_COUNT    4'h4
`define STM_OFS_MODE     4'h8
`define STM_ADR_START    8'h60
`define STM_ADR_STOP     8'h64
`define STM_ADR_STATUS   8'h68
`define STM_ADR_IRQ_STAT 8'h70
`define STM_ADR_IRQ_EN   8'h74
`define STM_ADR_IRQ_CLR  8'h78
`define STM_ADR_XTAL     8'h7C
`define STM_ADR_PMOD     8'h80

// Reset values
`define STM_DATA_RST 16'hFFFF
`define STM_MODE_RST 16'h0000
`define STM_PMOD_RST 8'h00

// Mode register fields
`define STM_MODE_SRC_LSB 0
`define STM_MODE_SRC_MSB 3
`define STM_MODE_DIV_LSB 4
`define STM_MODE_DIV_MSB 6
`define STM_MODE_ONESHOT 7
`define STM_MODE_INIT    8
`define STM_MODE_EXT_LSB 9
`define STM_MODE_EXT_MSB 11

// Port mode byte
`define STM_PMOD_FUNC 4'h5
`define STM_DRV_PP    4'h2
`define STM_DRV_OD    4'hA
`define STM_DRV_ODPU  4'hF

// Timing
`define STM_PCLK_HZ    10000000
`define STM_EXT_MAX_HZ 3000000

`endif

// >>> stm_pkg.sv
package stm_pkg;

  typedef enum logic [1:0]
  {
    CH_IDLE = 2'h0,
    CH_RUN  = 2'h1
  } stm_chan_e;

  typedef enum logic [3:0]
  {
    SRC_LS_A  = 4'h0,
    SRC_LS_B  = 4'h1,
    SRC_HS    = 4'h2,
    SRC_HTB_A = 4'h3,
    SRC_HTB_B = 4'h4,
    SRC_RC_KILOHERTZ_CLOCK  = 4'h5,
    SRC_EXT   = 4'h6,
    SRC_LOW_SPEED_TIMEBASE_COUNTER  = 4'h7,
    SRC_FTM   = 4'h8
  } stm_src_e;

endpackage

// >>> stm_sync3.sv
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"

module stm_sync3
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [`STM_NEXT-1:0]  pin_in,
  output logic      [`STM_NEXT-1:0]  rise
);

  typedef struct packed
  {
    logic [`STM_NEXT-1:0] q1;
    logic [`STM_NEXT-1:0] q2;
    logic [`STM_NEXT-1:0] q3;
    logic [`STM_NEXT-1:0] stable;
    logic [`STM_NEXT-1:0] rise;
  } stm_sync_s;

  stm_sync_s s_r;
  stm_sync_s s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.q1   = pin_in;
    s_nxt.q2   = s_r.q1;
    s_nxt.q3   = s_r.q2;
    // Level accepted only when second and third stage agree
    s_nxt.stable = (s_r.q2 & s_r.q3) | (s_r.stable & (s_r.q2 | s_r.q3));
    s_nxt.rise   = s_nxt.stable & ~s_r.stable;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rise = s_r.rise;

endmodule
`default_nettype wire

// >>> stm_chan.sv
`timescale 1ns/1ps
`default_nettype none

module stm_chan
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        src_tick,
  input  wire logic [2:0]  div,
  input  wire logic [15:0] data,
  input  wire logic        one_shot,
  input  wire logic        init_level,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  output logic      [15:0] count,
  output logic             running,
  output logic             match,
  output logic             level
);

  typedef struct packed
  {
    stm_pkg::stm_chan_e state;
    logic [15:0]        cnt;
    logic [2:0]         pre;
    logic               level;
    logic               fired;
    logic               match;
  } stm_chan_s;

  stm_chan_s s_r;
  stm_chan_s s_nxt;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.match = 1'b0;
    if (load)
      s_nxt.cnt = load_val;
    case (s_r.state)
      stm_pkg::CH_IDLE:
      begin
        if (!s_r.fired)
          s_nxt.level = init_level;
        if (start && !stop)
        begin
          s_nxt.state = stm_pkg::CH_RUN;
          s_nxt.pre   = 3'h0;
          s_nxt.fired = 1'b0;
          s_nxt.level = init_level;
        end
      end
      stm_pkg::CH_RUN:
      begin
        if (stop)
          s_nxt.state = stm_pkg::CH_IDLE;
        else if (src_tick && !load)
        begin
          // Divide selected source by div+1
          if (s_r.pre == div)
          begin
            s_nxt.pre = 3'h0;
            if (s_r.cnt == data)
              s_nxt.cnt = 16'h0000;
            else
              s_nxt.cnt = s_r.cnt + 16'h0001;
            if (s_nxt.cnt == data)
            begin
              s_nxt.match = 1'b1;
              s_nxt.level = ~s_r.level;
              s_nxt.fired = 1'b1;
              if (one_shot)
                s_nxt.state = stm_pkg::CH_IDLE;
            end
          end
          else
            s_nxt.pre = s_r.pre + 3'h1;
        end
      end
      default:
        s_nxt.state = stm_pkg::CH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign count   = s_r.cnt;
  assign running = (s_r.state == stm_pkg::CH_RUN);
  assign match   = s_r.match;
  assign level   = s_r.level;

endmodule
`default_nettype wire

// >>> stm_timer.sv
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "stm_defines.svh"

module stm_timer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        low_speed_clock_a,
  input  wire logic        low_speed_clock_b,
  input  wire logic        high_speed_clock,
  input  wire logic        hs_timebase_clock_a,
  input  wire logic        hs_timebase_clock_b,
  input  wire logic        rc_kilohertz_clock,
  input  wire logic        low_speed_timebase_counter,
  input  wire logic [5:0]  ftm_trigger,
  input  wire logic [7:0]  ext_interrupt_pin,
  input  wire logic        osc_stab_start,
  output logic             osc_stab_done,
  output logic [5:0]       channel_match_irq,
  output logic             timer_irq,
  output logic             pulse_out_ch2,
  output logic             pulse_out_ch3,
  output logic             pulse_out_ch4,
  output logic             pulse_out_chx,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe_n,
  output logic [3:0]       pin_pullup_en
);

  localparam int NCH = `STM_NCH;
  localparam int NPO = `STM_NPULSE;

  typedef struct packed
  {
    logic [NCH-1:0][15:0] data;
    logic [NCH-1:0][15:0] mode;
    logic [NPO-1:0][7:0]  pmod;
    logic [NCH-1:0]       irq_stat;
    logic [NCH-1:0]       irq_en;
    logic                 xtal_use;
    logic                 stab_done;
    logic [31:0]          prdata;
  } stm_top_s;

  stm_top_s s_r;
  stm_top_s s_nxt;

  // Channel-side wires
  logic [NCH-1:0][15:0] ch_count;
  logic [NCH-1:0]       ch_running;
  logic [NCH-1:0]       ch_match;
  logic [NCH-1:0]       ch_level;
  logic [NCH-1:0]       ch_tick;
  logic [NCH-1:0]       ch_start;
  logic [NCH-1:0]       ch_stop;
  logic [NCH-1:0]       ch_load;
  logic [7:0]           ext_rise;

  // Bus decode
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd_val;
  logic [NCH-1:0] hit_data;
  logic [NCH-1:0] hit_count;
  logic [NCH-1:0] hit_mode;
  logic [NPO-1:0] hit_pmod;

  // One-hot channel select for a given register offset
  function automatic logic [NCH-1:0] ch_hit
  (
    input logic [11:0] a,
    input logic [3:0]  ofs
  );
    logic [NCH-1:0] h;
    h = '0;
    for (int i = 0; i < NCH; i++)
    begin
      if (a[11:8] == 4'h0 && a[7:4] == 4'(i) && a[3:0] == ofs)
        h[i] = 1'b1;
    end
    return h;
  endfunction

  // Pick one-cycle count pulse for a channel
  function automatic logic src_pick
  (
    input logic [3:0] sel,
    input logic [8:0] src
  );
    logic r;
    r = 1'b0;
    case (sel)
      stm_pkg::SRC_LS_A:  r = src[0];
      stm_pkg::SRC_LS_B:  r = src[1];
      stm_pkg::SRC_HS:    r = src[2];
      stm_pkg::SRC_HTB_A: r = src[3];
      stm_pkg::SRC_HTB_B: r = src[4];
      stm_pkg::SRC_RC_KILOHERTZ_CLOCK:  r = src[5];
      stm_pkg::SRC_EXT:   r = src[6];
      stm_pkg::SRC_LOW_SPEED_TIMEBASE_COUNTER:  r = src[7];
      stm_pkg::SRC_FTM:   r = src[8];
      default:            r = 1'b0;
    endcase
    return r;
  endfunction

  // External trigger pins, already filtered, synchronised here
  stm_sync3 u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ext_interrupt_pin),
    .rise    (ext_rise)
  );

  assign acc = psel && penable;
  assign wr  = acc && pwrite && hit;

  always_comb
  begin
    hit_data  = ch_hit(paddr, `STM_OFS_DATA);
    hit_count = ch_hit(paddr, `STM_OFS_COUNT);
    hit_mode  = ch_hit(paddr, `STM_OFS_MODE);
    for (int p = 0; p < NPO; p++)
    begin
      hit_pmod[p] = (paddr == {4'h0, `STM_ADR_PMOD + 8'(4 * p)});
    end
  end

  always_comb
  begin
    hit = (|hit_data) || (|hit_count) || (|hit_mode) || (|hit_pmod)
      || paddr == {4'h0, `STM_ADR_START}
      || paddr == {4'h0, `STM_ADR_STOP}
      || paddr == {4'h0, `STM_ADR_STATUS}
      || paddr == {4'h0, `STM_ADR_IRQ_STAT}
      || paddr == {4'h0, `STM_ADR_IRQ_EN}
      || paddr == {4'h0, `STM_ADR_IRQ_CLR}
      || paddr == {4'h0, `STM_ADR_XTAL};
  end

  // Read mux; write-only registers read zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    for (int i = 0; i < NCH; i++)
    begin
      if (hit_data[i])
        rd_val = {16'h0000, s_r.data[i]};
      if (hit_count[i])
        rd_val = {16'h0000, ch_count[i]};
      if (hit_mode[i])
        rd_val = {16'h0000, s_r.mode[i]};
    end
    for (int p = 0; p < NPO; p++)
    begin
      if (hit_pmod[p])
        rd_val = {24'h000000, s_r.pmod[p]};
    end
    if (paddr == {4'h0, `STM_ADR_STATUS})
      rd_val = {26'h0000000, ch_running};
    if (paddr == {4'h0, `STM_ADR_IRQ_STAT})
      rd_val = {26'h0000000, s_r.irq_stat};
    if (paddr == {4'h0, `STM_ADR_IRQ_EN})
      rd_val = {26'h0000000, s_r.irq_en};
    if (paddr == {4'h0, `STM_ADR_XTAL})
      rd_val = {31'h00000000, s_r.xtal_use};
  end

  // Start, stop and counter loads are single-cycle write pulses
  always_comb
  begin
    ch_start = '0;
    ch_stop  = '0;
    ch_load  = hit_count & {NCH{wr}};
    if (wr && paddr == {4'h0, `STM_ADR_START})
      ch_start = pwdata[NCH-1:0];
    if (wr && paddr == {4'h0, `STM_ADR_STOP})
      ch_stop = pwdata[NCH-1:0];
    // Oscillator stability check may launch channel X
    if (s_r.xtal_use && osc_stab_start)
      ch_start[`STM_CHX] = 1'b1;
  end

  // Count pulse per channel
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      ch_tick[i] = src_pick(
        s_r.mode[i][`STM_MODE_SRC_MSB:`STM_MODE_SRC_LSB],
        {ftm_trigger[i],
         low_speed_timebase_counter,
         ext_rise[s_r.mode[i][`STM_MODE_EXT_MSB:`STM_MODE_EXT_LSB]],
         rc_kilohertz_clock,
         hs_timebase_clock_b,
         hs_timebase_clock_a,
         high_speed_clock,
         low_speed_clock_b,
         low_speed_clock_a});
    end
  end

  // Only channels 0..4 and X are built
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      stm_chan u_chan
      (
        .pclk       (pclk),
        .presetn    (presetn),
        .src_tick   (ch_tick[g]),
        .div        (s_r.mode[g][`STM_MODE_DIV_MSB:`STM_MODE_DIV_LSB]),
        .data       (s_r.data[g]),
        .one_shot   (s_r.mode[g][`STM_MODE_ONESHOT]),
        .init_level (s_r.mode[g][`STM_MODE_INIT]),
        .start      (ch_start[g]),
        .stop       (ch_stop[g]),
        .load       (ch_load[g]),
        .load_val   (pwdata[15:0]),
        .count      (ch_count[g]),
        .running    (ch_running[g]),
        .match      (ch_match[g]),
        .level      (ch_level[g])
      );
    end
  endgenerate

  // Register file and interrupt status
  always_comb
  begin
    s_nxt = s_r;
    if (psel && !penable)
      s_nxt.prdata = rd_val;
    for (int i = 0; i < NCH; i++)
    begin
      if (wr && hit_data[i])
        s_nxt.data[i] = pwdata[15:0];
      if (wr && hit_mode[i])
        s_nxt.mode[i] = pwdata[15:0];
    end
    for (int p = 0; p < NPO; p++)
    begin
      if (wr && hit_pmod[p])
        s_nxt.pmod[p] = pwdata[7:0];
    end
    if (wr && paddr == {4'h0, `STM_ADR_IRQ_EN})
      s_nxt.irq_en = pwdata[NCH-1:0];
    if (wr && paddr == {4'h0, `STM_ADR_XTAL})
      s_nxt.xtal_use = pwdata[0];
    // A match in the clear cycle stays set
    if (wr && paddr == {4'h0, `STM_ADR_IRQ_CLR})
      s_nxt.irq_stat = s_r.irq_stat & ~pwdata[NCH-1:0];
    s_nxt.irq_stat = s_nxt.irq_stat | ch_match;
    s_nxt.stab_done = s_r.xtal_use && ch_match[`STM_CHX];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r          <= '0;
      s_r.data     <= {NCH{`STM_DATA_RST}};
      s_r.mode     <= {NCH{`STM_MODE_RST}};
      s_r.pmod     <= {NPO{`STM_PMOD_RST}};
    end
    else
      s_r <= s_nxt;
  end

  // Port output drivers for channels 2, 3, 4 and X
  logic [NPO-1:0] po_level;
  assign po_level = ch_level[`STM_CHX:`STM_PULSE_BASE];

  generate
    for (g = 0; g < NPO; g++)
    begin : g_drv
      logic       sel_fn;
      logic [3:0] drv;
      // Pin follows the timer only with the sixth-function code
      assign sel_fn = (s_r.pmod[g][7:4] == `STM_PMOD_FUNC);
      assign drv    = s_r.pmod[g][3:0];
      always_comb
      begin
        pin_out[g]       = 1'b0;
        pin_oe_n[g]      = 1'b1;
        pin_pullup_en[g] = 1'b0;
        if (sel_fn)
        begin
          case (drv)
            `STM_DRV_PP:
            begin
              pin_out[g]  = po_level[g];
              pin_oe_n[g] = 1'b0;
            end
            `STM_DRV_OD:
            begin
              pin_oe_n[g] = po_level[g];
            end
            `STM_DRV_ODPU:
            begin
              pin_oe_n[g]      = po_level[g];
              pin_pullup_en[g] = 1'b1;
            end
            default:
              pin_oe_n[g] = 1'b1;
          endcase
        end
      end
    end
  endgenerate

  assign pulse_out_ch2 = ch_level[2];
  assign pulse_out_ch3 = ch_level[3];
  assign pulse_out_ch4 = ch_level[4];
  assign pulse_out_chx = ch_level[`STM_CHX];

  assign channel_match_irq = ch_match;
  assign timer_irq         = |(s_r.irq_stat & s_r.irq_en);
  assign osc_stab_done     = s_r.stab_done;

  assign prdata  = s_r.prdata;
  assign pready  = acc;
  assign pslverr = acc && !hit;

endmodule
`default_nettype wire

// >>> stm_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none

module stm_timer_sva
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  channel_match_irq,
  input wire logic        timer_irq,
  input wire logic        pulse_out_ch2,
  input wire logic        pulse_out_ch4,
  input wire logic        pulse_out_chx,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe_n,
  input wire logic [3:0]  pin_pullup_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_access: assert property (pready == (psel && penable))
    else $error("pready outside access phase");
  a_err_unmapped: assert property
    (psel && penable && paddr == 12'h090 |-> pslverr)
    else $error("unmapped access without error");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data changed outside setup");
  a_irq_cause: assert property ($rose(timer_irq) |->
    $past(|channel_match_irq) || $past(psel && penable && pwrite))
    else $error("interrupt rose without match or write");
  a_toggle_on_match: assert property (
    channel_match_irq[2] |-> pulse_out_ch2 != $past(pulse_out_ch2))
    else $error("match without output toggle");
  a_level_cause: assert property ($changed(pulse_out_chx) |->
    channel_match_irq[5] || $past(psel && penable && pwrite)
    || $past(psel && penable && pwrite, 2))
    else $error("output level moved without cause");
  a_drive_level: assert property (
    !pin_oe_n[0] |-> pin_out[0] == pulse_out_ch2)
    else $error("driven pin differs from channel level");
  a_pullup_open: assert property (
    pin_pullup_en[2] |-> !pin_out[2] && pin_oe_n[2] == pulse_out_ch4)
    else $error("pull-up mode not open drain");

  c_repeat: cover property (channel_match_irq[2] ##3 channel_match_irq[2]);
  c_irq: cover property ($rose(timer_irq));
  c_ext: cover property (channel_match_irq[0]);
endmodule

`default_nettype wire

// >>> stm_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module stm_port_model
(
  input  wire logic       pclk,
  output logic      [7:0] ext_interrupt_pin
);
  initial ext_interrupt_pin = 8'h00;

  // Two cycles high, two low: 2.5 MHz, under the external clock ceiling
  task automatic send_ext(input int pin, input int n);
    for (int i = 0; i < n; i++)
    begin
      ext_interrupt_pin[pin] <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_interrupt_pin[pin] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
endmodule

`default_nettype wire

// >>> sixteen_bit_match_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sixteen_bit_match_timer_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [8:0]  src_p;
  logic [7:0]  ext_interrupt_pin;
  logic [5:0]  channel_match_irq;
  logic        timer_irq;
  logic [3:0]  pulse_out;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe_n;
  logic [3:0]  pin_pullup_en;
  logic [31:0] rd;
  logic        er;
  logic        stab_start;
  logic        stab_done;
  int          errors = 0;
  int          total_checks = 0;
  int          ext_hits = 0;

  stm_timer dut_u
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .low_speed_clock_a(src_p[0]),
    .low_speed_clock_b(src_p[1]), .high_speed_clock(src_p[2]),
    .hs_timebase_clock_a(src_p[3]), .hs_timebase_clock_b(src_p[4]),
    .rc_kilohertz_clock(src_p[5]), .low_speed_timebase_counter(src_p[7]),
    .ftm_trigger({4'h0, src_p[8], 1'b0}), .ext_interrupt_pin,
    .osc_stab_start(stab_start), .osc_stab_done(stab_done),
    .channel_match_irq,
    .timer_irq, .pulse_out_ch2(pulse_out[0]), .pulse_out_ch3(pulse_out[1]),
    .pulse_out_ch4(pulse_out[2]), .pulse_out_chx(pulse_out[3]),
    .pin_out, .pin_oe_n, .pin_pullup_en
  );

  stm_port_model port_u (.pclk, .ext_interrupt_pin);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (channel_match_irq[0] === 1'b1)
      ext_hits <= ext_hits + 1;

  task automatic final_report;
    if (errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      errors++;
      final_report;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wmatch(input int ch, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (channel_match_irq[ch] !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      errors++;
      final_report;
    end
  endtask

  task automatic t_reset;
    chk(pin_oe_n, 4'hF);
    rdc(12'h000, 32'h0000FFFF);
    rdc(12'h050, 32'h0000FFFF);
    rdc(12'h008, 32'h0);
    rdc(12'h090, 32'h0);
    chk(er, 1'b1);
  endtask

  task automatic t_sources;
    int n;
    wr(12'h010, 32'h0);
    for (int s = 0; s < 9; s++)
    begin
      if (s != 6)
      begin
        wr(12'h018, 32'(s));
        wr(12'h060, 32'h2);
        src_p[s] <= 1'b1;
        @(posedge pclk);
        src_p[s] <= 1'b0;
        wmatch(1, n);
        chk(n <= 3, 1'b1);
        wr(12'h064, 32'h2);
      end
    end
  endtask

  task automatic t_repeat;
    int n;
    wr(12'h020, 32'h2);
    wr(12'h028, 32'h102);
    wr(12'h080, 32'h52);
    src_p[2] <= 1'b1;
    chk(pulse_out[0], 1'b1);
    chk({pin_oe_n[0], pin_out[0]}, 2'b01);
    rdc(12'h024, 32'h0);
    wr(12'h074, 32'h4);
    wr(12'h060, 32'h4);
    wmatch(2, n);
    chk(pulse_out[0], 1'b0);
    wmatch(2, n);
    chk(n, 3);
    chk({pulse_out[0], timer_irq}, 2'b11);
    rdc(12'h068, 32'h4);
    wr(12'h064, 32'h4);
    rdc(12'h068, 32'h0);
    wr(12'h074, 32'h0);
    chk(timer_irq, 1'b0);
    rdc(12'h070, 32'h6);
    wr(12'h078, 32'h6);
    rdc(12'h070, 32'h0);
  endtask

  task automatic t_oneshot;
    int n;
    int hits;
    hits = 0;
    wr(12'h030, 32'h1);
    wr(12'h038, 32'h0B0);
    src_p[0] <= 1'b1;
    wr(12'h060, 32'h8);
    wmatch(3, n);
    chk(n > 3 && n < 9, 1'b1);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge pclk);
      hits += int'(channel_match_irq[3]);
    end
    chk(hits, 0);
    chk(pulse_out[1], 1'b1);
    rdc(12'h068, 32'h0);
    rdc(12'h034, 32'h1);
    wr(12'h034, 32'h5);
    rdc(12'h034, 32'h5);
    src_p[0] <= 1'b0;
  endtask

  task automatic t_pins;
    int n;
    wr(12'h040, 32'h0);
    wr(12'h048, 32'h072);
    wr(12'h088, 32'h5F);
    wr(12'h050, 32'h1);
    wr(12'h058, 32'h002);
    wr(12'h08C, 32'h5A);
    wr(12'h060, 32'h30);
    wmatch(4, n);
    wmatch(4, n);
    chk(n, 8);
    chk(pulse_out[2], 1'b0);
    chk({pin_out[2], pin_pullup_en[2], pin_oe_n[2]}, 3'b010);
    wmatch(5, n);
    wmatch(5, n);
    chk(n, 2);
    chk(stab_done, 1'b0);
    chk(pulse_out[3], 1'b0);
    chk({pin_out[3], pin_pullup_en[3], pin_oe_n[3]}, 3'b000);
    wr(12'h08C, 32'h3A);
    chk(pin_oe_n[3], 1'b1);
    wr(12'h064, 32'h30);
  endtask

  task automatic t_xtal;
    int n;
    wr(12'h07C, 32'h1);
    stab_start <= 1'b1;
    @(posedge pclk);
    stab_start <= 1'b0;
    rdc(12'h068, 32'h20);
    wmatch(5, n);
    @(posedge pclk);
    chk(stab_done, 1'b1);
    wr(12'h064, 32'h20);
    wr(12'h07C, 32'h0);
  endtask

  task automatic t_ext;
    wr(12'h000, 32'h3);
    wr(12'h008, 32'h206);
    wr(12'h060, 32'h1);
    port_u.send_ext(1, 3);
    repeat (6) @(posedge pclk);
    chk(ext_hits, 1);
    rdc(12'h004, 32'h3);
    wr(12'h064, 32'h1);
  endtask

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    src_p   = 9'h000;
    stab_start = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_sources;
    t_repeat;
    t_oneshot;
    t_pins;
    t_xtal;
    t_ext;
    final_report;
  end
endmodule

bind stm_timer stm_timer_sva chk_u
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .channel_match_irq, .timer_irq, .pulse_out_ch2, .pulse_out_ch4,
  .pulse_out_chx,
  .pin_out, .pin_oe_n, .pin_pullup_en
);

`default_nettype wire
